// ### src/lacc_core.sv
// Load-adaptive coil current loop: APB register file, load averaging, learning and PD current update
`timescale 1ns/1ps

module lacc_core
  import lacc_pkg::*;
#(
  parameter logic [7:0] LEARN_LEN = LEARN_HALF_CYCLES
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_reset,
  // APB slave
  input  wire logic         i_psel,
  input  wire logic         i_penable,
  input  wire logic         i_pwrite,
  input  wire logic [11:0]  i_paddr,
  input  wire logic [31:0]  i_pwdata,
  input  wire logic [3:0]   i_pstrb,
  output logic      [31:0]  o_prdata,
  output logic              o_pready,
  output logic              o_pslverr,
  // Motor side
  input  wire logic         i_half_cycle,
  input  wire logic [10:0]  i_load_sample,
  output logic      [7:0]   o_current_value,
  output logic      [10:0]  o_load_counter,
  output logic      [10:0]  o_final_learn_param,
  output logic              o_adaptive_enable,
  output logic              o_learning_active
);

  // ==========================================================================
  // State
  // ==========================================================================
  lacc_state_t st;
  lacc_state_t next_st;

  logic [7:0]  idx;
  logic [7:0]  rd_byte;
  logic        hit;
  logic        access;
  logic        commit;
  logic [7:0]  wbyte;

  // Register index from the word address
  assign idx    = i_paddr[ADDR_IDX_LSB +: 8];
  assign access = i_psel & i_penable;
  // A write lands only on the edge that also sees pready high
  assign commit = access & st.pready & i_pwrite & hit & i_pstrb[0];
  assign wbyte  = i_pwdata[7:0];

  // ==========================================================================
  // Read decode
  // ==========================================================================
  // Reserved bits read as zero
  always_comb begin
    rd_byte = 8'h00;
    hit     = 1'b1;
    if (idx == IDX_LOAD_LO) begin
      rd_byte = st.load_cnt[7:0];
    end else if (idx == IDX_LOAD_HI) begin
      rd_byte = {st.load_cnt[10:8], 5'h00};
    end else if (idx == IDX_LEARN_HI) begin
      rd_byte = st.learn_hi;
    end else if (idx == IDX_FINAL_LO) begin
      rd_byte = st.final_lo;
    end else if (idx == IDX_UPPER) begin
      rd_byte = st.upper;
    end else if (idx == IDX_LOWER) begin
      rd_byte = st.lower;
    end else if (idx == IDX_PGAIN) begin
      rd_byte = st.pgain;
    end else if (idx == IDX_DGAIN) begin
      rd_byte = {4'h0, st.dgain};
    end else if (idx == IDX_CTRL) begin
      rd_byte = {st.enable, st.trigger, st.delay, st.avg};
    end else if (idx == IDX_FLOOR) begin
      rd_byte = st.floor_lvl;
    end else if (idx == IDX_CEIL) begin
      rd_byte = st.ceil_lvl;
    end else if (idx == IDX_OUT) begin
      rd_byte = st.current;
    end else begin
      hit = 1'b0;
    end
  end

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    logic [13:0] acc;
    logic [13:0] s2;
    logic [13:0] s4;
    logic [13:0] lc_wide;
    logic [10:0] err;
    logic [10:0] de;
    logic        up;
    logic        dn;
    logic [18:0] pterm;
    logic [14:0] dterm;
    logic [19:0] step;
    logic [7:0]  step8;
    logic [9:0]  tmp;
    logic        finish;
    acc     = 14'h0000;
    s2      = 14'h0000;
    s4      = 14'h0000;
    lc_wide = 14'h0000;
    err     = 11'h000;
    de      = 11'h000;
    up      = 1'b0;
    dn      = 1'b0;
    pterm   = 19'h00000;
    dterm   = 15'h0000;
    step    = 20'h00000;
    step8   = 8'h00;
    tmp     = 10'h000;
    finish  = 1'b0;
    next_st = st;

    // APB answer: one wait state, then pready for exactly one cycle
    next_st.pready  = 1'b0;
    next_st.pslverr = 1'b0;
    if (access & !st.pready) begin
      next_st.pready  = 1'b1;
      next_st.pslverr = !hit;
      next_st.prdata  = {24'h000000, rd_byte};
    end

    // Sample history shifts once per electrical half-cycle
    if (i_half_cycle) begin
      next_st.hist[0] = i_load_sample;
      for (int k = 1; k < HIST_DEPTH; k++) begin
        next_st.hist[k] = st.hist[k-1];
      end
    end

    // Moving average over the selected depth; lags the history by one clock
    for (int k = 0; k < HIST_DEPTH; k++) begin
      acc = acc + {3'b000, st.hist[k]};
      if (k == 1) begin
        s2 = acc;
      end
      if (k == 3) begin
        s4 = acc;
      end
    end
    case (st.avg)
      AVG_2: lc_wide = s2 >> 1;
      AVG_4: lc_wide = s4 >> 2;
      AVG_8: lc_wide = acc >> 3;
      default: lc_wide = {3'b000, st.hist[0]};
    endcase
    next_st.load_cnt = lc_wide[10:0];

    // Band error: only the distance outside the band drives the loop
    if (st.load_cnt > {3'b000, st.upper}) begin
      up  = 1'b1;
      err = st.load_cnt - {3'b000, st.upper};
    end else if (st.load_cnt < {3'b000, st.lower}) begin
      dn  = 1'b1;
      err = {3'b000, st.lower} - st.load_cnt;
    end
    // Derivative acts on growth of the error only, which damps overshoot
    de    = (err > st.err_prev) ? (err - st.err_prev) : 11'h000;
    pterm = (19'(st.pgain) * 19'(err)) >> GAIN_SHIFT;
    dterm = 15'(st.dgain) * 15'(de);
    step  = 20'(pterm) + 20'(dterm);
    step8 = (step > 20'h000ff) ? 8'hff : step[7:0];

    // Current update gated by the half-cycle delay counter
    if (!st.enable) begin
      next_st.current  = st.ceil_lvl;
      next_st.dly_cnt  = 3'h0;
      next_st.err_prev = 11'h000;
    end else if (i_half_cycle) begin
      // A zero delay field behaves as one half-cycle
      if ((st.dly_cnt + 3'h1) >= st.delay) begin
        next_st.dly_cnt  = 3'h0;
        next_st.err_prev = err;
        tmp = {2'b00, st.current};
        if (up) begin
          tmp = {2'b00, st.current} + {2'b00, step8};
        end else if (dn) begin
          tmp = (st.current > step8) ? {2'b00, st.current - step8} : 10'h000;
        end
        // Ceiling is checked last so it wins over a floor set above it
        if (tmp < {2'b00, st.floor_lvl}) begin
          tmp = {2'b00, st.floor_lvl};
        end
        if (tmp > {2'b00, st.ceil_lvl}) begin
          tmp = {2'b00, st.ceil_lvl};
        end
        next_st.current = tmp[7:0];
      end else begin
        next_st.dly_cnt = st.dly_cnt + 3'h1;
        // A counting pulse must not let a freshly narrowed limit slip by
        if (st.current < st.floor_lvl) begin
          next_st.current = st.floor_lvl;
        end
        if (st.current > st.ceil_lvl) begin
          next_st.current = st.ceil_lvl;
        end
      end
    end else begin
      // Limits changed by software take hold even between half-cycles
      if (st.current < st.floor_lvl) begin
        next_st.current = st.floor_lvl;
      end
      if (st.current > st.ceil_lvl) begin
        next_st.current = st.ceil_lvl;
      end
    end

    // Learning routine: runs a fixed number of half-cycles, then captures
    case (st.lrn)
      LRN_IDLE: begin
        if (st.trigger) begin
          next_st.lrn     = LRN_RUN;
          next_st.lrn_cnt = 8'h00;
        end
      end
      LRN_RUN: begin
        if (i_half_cycle) begin
          if ((st.lrn_cnt + 8'h01) >= LEARN_LEN) begin
            finish           = 1'b1;
            next_st.lrn      = LRN_IDLE;
            next_st.trigger  = 1'b0;
            next_st.final_lo = st.load_cnt[7:0];
            next_st.learn_hi = {st.learn_hi[7:3], st.load_cnt[10:8]};
          end else begin
            next_st.lrn_cnt = st.lrn_cnt + 8'h01;
          end
        end
      end
      default: begin
        next_st.lrn = LRN_IDLE;
      end
    endcase

    // Software writes; placed last so a new trigger beats the finishing clear
    if (commit) begin
      if (idx == IDX_LEARN_HI) begin
        next_st.learn_hi = wbyte;
      end else if (idx == IDX_FINAL_LO) begin
        next_st.final_lo = wbyte;
      end else if (idx == IDX_UPPER) begin
        next_st.upper = wbyte;
      end else if (idx == IDX_LOWER) begin
        next_st.lower = wbyte;
      end else if (idx == IDX_PGAIN) begin
        next_st.pgain = wbyte;
      end else if (idx == IDX_DGAIN) begin
        next_st.dgain = wbyte[DGAIN_W-1:0];
      end else if (idx == IDX_CTRL) begin
        next_st.enable = wbyte[CTRL_EN_BIT];
        next_st.delay  = wbyte[CTRL_DLY_LSB +: 3];
        next_st.avg    = wbyte[CTRL_AVG_LSB +: 3];
        // Writing zero cannot abort a running learn
        if (wbyte[CTRL_TRIG_BIT]) begin
          next_st.trigger = 1'b1;
          if (finish) begin
            next_st.lrn     = LRN_RUN;
            next_st.lrn_cnt = 8'h00;
          end
        end
      end else if (idx == IDX_FLOOR) begin
        next_st.floor_lvl = wbyte;
      end else if (idx == IDX_CEIL) begin
        next_st.ceil_lvl = wbyte;
      end
    end
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st           <= '0;
      st.final_lo  <= RST_BYTE;
      st.learn_hi  <= RST_LEARN_HI;
      st.upper     <= RST_BYTE;
      st.lower     <= RST_BYTE;
      st.pgain     <= RST_BYTE;
      st.delay     <= RST_DELAY;
      st.avg       <= RST_AVG;
      st.floor_lvl <= RST_FLOOR;
      st.ceil_lvl  <= RST_CEIL;
      st.current   <= RST_CEIL;
      st.lrn       <= LRN_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Outputs, all straight from the state register
  // ==========================================================================
  assign o_prdata            = st.prdata;
  assign o_pready            = st.pready;
  assign o_pslverr           = st.pslverr;
  assign o_current_value     = st.current;
  assign o_load_counter      = st.load_cnt;
  assign o_final_learn_param = {st.learn_hi[2:0], st.final_lo};
  assign o_adaptive_enable   = st.enable;
  assign o_learning_active   = st.trigger;

endmodule

// ### src/lacc_pkg.sv
// Package: register map, field layout, reset values and state carrier of the adaptive current loop block
package lacc_pkg;

  // ==========================================================================
  // Register indices (byte address = index * 4)
  // ==========================================================================
  localparam logic [7:0] IDX_LOAD_LO    = 8'h1f;
  localparam logic [7:0] IDX_LOAD_HI    = 8'h20;
  localparam logic [7:0] IDX_LEARN_HI   = 8'h22;
  localparam logic [7:0] IDX_FINAL_LO   = 8'h23;
  localparam logic [7:0] IDX_UPPER      = 8'h24;
  localparam logic [7:0] IDX_LOWER      = 8'h25;
  localparam logic [7:0] IDX_PGAIN      = 8'h26;
  localparam logic [7:0] IDX_DGAIN      = 8'h27;
  localparam logic [7:0] IDX_CTRL       = 8'h28;
  localparam logic [7:0] IDX_FLOOR      = 8'h29;
  localparam logic [7:0] IDX_CEIL       = 8'h2a;
  localparam logic [7:0] IDX_OUT        = 8'h2e;
  localparam int         ADDR_IDX_LSB   = 2;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int CTRL_EN_BIT    = 7;
  localparam int CTRL_TRIG_BIT  = 6;
  localparam int CTRL_DLY_LSB   = 3;
  localparam int CTRL_AVG_LSB   = 0;
  localparam int LOAD_HI_LSB    = 5;
  localparam int DGAIN_W        = 4;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  localparam logic [7:0]  RST_LEARN_HI  = 8'h20;
  localparam logic [2:0]  RST_DELAY     = 3'h1;
  localparam logic [2:0]  RST_AVG       = 3'h0;
  localparam logic [7:0]  RST_FLOOR     = 8'h0a;
  localparam logic [7:0]  RST_CEIL      = 8'hff;

  // ==========================================================================
  // Averaging codes, loop scaling and learning length
  // ==========================================================================
  localparam logic [2:0]  AVG_2         = 3'h2;
  localparam logic [2:0]  AVG_4         = 3'h4;
  localparam logic [2:0]  AVG_8         = 3'h7;
  localparam int          HIST_DEPTH    = 8;
  localparam int          GAIN_SHIFT    = 4;
  localparam logic [7:0]  LEARN_HALF_CYCLES = 8'h10;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    LRN_IDLE = 2'b01,
    LRN_RUN  = 2'b10
  } lacc_lrn_t;

  typedef struct packed {
    logic [31:0]               prdata;
    logic                      pready;
    logic                      pslverr;
    logic [7:0]                final_lo;
    logic [7:0]                learn_hi;
    logic [7:0]                upper;
    logic [7:0]                lower;
    logic [7:0]                pgain;
    logic [DGAIN_W-1:0]        dgain;
    logic                      enable;
    logic                      trigger;
    logic [2:0]                delay;
    logic [2:0]                avg;
    logic [7:0]                floor_lvl;
    logic [7:0]                ceil_lvl;
    logic [7:0]                current;
    logic [10:0]               load_cnt;
    logic [HIST_DEPTH-1:0][10:0] hist;
    logic [10:0]               err_prev;
    logic [2:0]                dly_cnt;
    logic [7:0]                lrn_cnt;
    lacc_lrn_t                 lrn;
  } lacc_state_t;

endpackage

// ### test/lacc_core_sva.sv
// Checker: bus timing, control bits, learning capture and current limits of the adaptive loop
`timescale 1ns/1ps
module lacc_core_sva
  import lacc_pkg::*;
#(
  parameter logic [7:0] LEARN_LEN = LEARN_HALF_CYCLES
) (
  // Clock and reset
  input wire logic        i_clk,
  input wire logic        i_reset,
  // APB slave
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0]  i_pstrb,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  // Motor side
  input wire logic        i_half_cycle,
  input wire logic [10:0] i_load_sample,
  input wire logic [7:0]  o_current_value,
  input wire logic [10:0] o_load_counter,
  input wire logic [10:0] o_final_learn_param,
  input wire logic        o_adaptive_enable,
  input wire logic        o_learning_active
);
  // ==========================================================================
  // Decoded writes and shadow limits
  // ==========================================================================
  logic [7:0] idx;
  logic       mapped;
  logic       wr;
  logic       wr_ctrl;
  logic       wr_fin;
  logic       wr_lim;
  logic [7:0] up_sh;
  logic [7:0] lo_sh;
  logic [7:0] fl_sh;
  logic [7:0] ce_sh;
  // A write counts only at the pready edge with the low lane strobed
  assign idx     = i_paddr[9:2];
  assign mapped  = idx inside {IDX_LOAD_LO, IDX_LOAD_HI, IDX_OUT, [IDX_LEARN_HI:IDX_CEIL]};
  assign wr      = i_psel && i_penable && i_pwrite && o_pready && i_pstrb[0] && mapped;
  assign wr_ctrl = wr && (idx == IDX_CTRL);
  assign wr_fin  = wr && (idx == IDX_FINAL_LO || idx == IDX_LEARN_HI);
  assign wr_lim  = wr && (idx == IDX_FLOOR || idx == IDX_CEIL);
  // Shadows let the current checks see the limits without reaching into the body
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      up_sh <= RST_BYTE;
      lo_sh <= RST_BYTE;
      fl_sh <= RST_FLOOR;
      ce_sh <= RST_CEIL;
    end else if (wr) begin
      if (idx == IDX_UPPER) up_sh <= i_pwdata[7:0];
      if (idx == IDX_LOWER) lo_sh <= i_pwdata[7:0];
      if (idx == IDX_FLOOR) fl_sh <= i_pwdata[7:0];
      if (idx == IDX_CEIL) ce_sh <= i_pwdata[7:0];
    end
  end

  // ==========================================================================
  // Properties
  // ==========================================================================
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);

  property p_ready_wait; $rose(i_penable) && i_psel |-> !o_pready ##1 o_pready; endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("pready not after one wait state");
  property p_ready_pulse; o_pready |=> !o_pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
  property p_err_map; (o_pready || o_pslverr) |-> o_pready && (o_pslverr == !mapped); endproperty
  a_err_map: assert property (p_err_map) else $error("pslverr does not match address decode");
  property p_rd_zero; o_pready && !i_pwrite && (idx == IDX_DGAIN) |-> o_prdata[31:4] == 28'h0000000; endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("reserved gain bits read nonzero");
  property p_en_src;
    $changed(o_adaptive_enable) |-> $past(wr_ctrl) && (o_adaptive_enable == $past(i_pwdata[CTRL_EN_BIT]));
  endproperty
  a_en_src: assert property (p_en_src) else $error("enable changed without control write");
  property p_trig_src; $rose(o_learning_active) |-> $past(wr_ctrl) && $past(i_pwdata[CTRL_TRIG_BIT]); endproperty
  a_trig_src: assert property (p_trig_src) else $error("learning started without trigger");
  property p_learn_cap;
    $fell(o_learning_active) && !$past(wr_fin) |-> o_final_learn_param == $past(o_load_counter);
  endproperty
  a_learn_cap: assert property (p_learn_cap) else $error("learning end did not capture load");
  property p_fin_src;
    $changed(o_final_learn_param)
      |-> $past(wr_fin) || $fell(o_learning_active) || $past(wr_ctrl && i_pwdata[CTRL_TRIG_BIT]);
  endproperty
  a_fin_src: assert property (p_fin_src) else $error("final parameter changed on its own");
  property p_off_ceil;
    !o_adaptive_enable && !$past(o_adaptive_enable) && !$past(wr_lim) |-> o_current_value == ce_sh;
  endproperty
  a_off_ceil: assert property (p_off_ceil) else $error("disabled current not at ceiling");
  property p_on_range;
    o_adaptive_enable && $past(o_adaptive_enable) && !$past(wr_lim) && (fl_sh <= ce_sh)
      |-> (o_current_value <= ce_sh) && (o_current_value >= fl_sh);
  endproperty
  a_on_range: assert property (p_on_range) else $error("enabled current outside limits");
  property p_band_hold;
    o_adaptive_enable && $past(o_adaptive_enable) && i_half_cycle && !wr_lim && !$past(wr_lim)
      && (o_load_counter <= up_sh) && (o_load_counter >= lo_sh) |=> $stable(o_current_value);
  endproperty
  a_band_hold: assert property (p_band_hold) else $error("current moved inside band");

  c_trigger: cover property (wr_ctrl && i_pwdata[CTRL_TRIG_BIT]);
  c_learn_done: cover property ($fell(o_learning_active));
  c_refused: cover property (o_pslverr);
  c_update: cover property (o_adaptive_enable && $changed(o_current_value));
endmodule

bind lacc_core lacc_core_sva #(.LEARN_LEN(LEARN_LEN)) u_lacc_core_sva (
  .i_clk(i_clk), .i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
  .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .i_half_cycle(i_half_cycle), .i_load_sample(i_load_sample),
  .o_current_value(o_current_value), .o_load_counter(o_load_counter),
  .o_final_learn_param(o_final_learn_param), .o_adaptive_enable(o_adaptive_enable),
  .o_learning_active(o_learning_active));

// ### test/test_lacc_core.sv
// Testbench: register map, averaging, learning and current loop of the adaptive current block
`timescale 1ns/1ps
module test_lacc_core;
  import lacc_pkg::*;
  // ==========================================================================
  // Signals and design
  // ==========================================================================
  logic        i_clk, i_reset, i_psel, i_penable, i_pwrite, i_half_cycle;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata;
  logic [3:0]  i_pstrb;
  logic        o_pready, o_pslverr, o_adaptive_enable, o_learning_active;
  logic [10:0] i_load_sample, o_load_counter, o_final_learn_param;
  logic [7:0]  o_current_value;
  int          n_mismatch = 0;
  int          checks_done = 0;
  // Short learning run keeps the test brief
  lacc_core #(.LEARN_LEN(8'h02)) u_lacc_core (
    .i_clk(i_clk), .i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_half_cycle(i_half_cycle), .i_load_sample(i_load_sample),
    .o_current_value(o_current_value), .o_load_counter(o_load_counter),
    .o_final_learn_param(o_final_learn_param), .o_adaptive_enable(o_adaptive_enable),
    .o_learning_active(o_learning_active));

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] ix, input logic [7:0] d, input logic [7:0] exp,
                     input logic err);
    int n;
    n = 0;
    @(posedge i_clk);
    i_psel   <= 1'b1;
    i_pwrite <= w;
    i_paddr  <= {2'b00, ix, 2'b00};
    i_pwdata <= {24'h000000, d};
    @(posedge i_clk);
    i_penable <= 1'b1;
    @(posedge i_clk);
    while (o_pready !== 1'b1 && n < 20) begin
      @(posedge i_clk);
      n++;
    end
    if (o_pready !== 1'b1) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: no pready within limit", $time);
    end
    check({31'h0, o_pslverr}, {31'h0, err});
    if (!w) check(o_prdata, {24'h000000, exp});
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
  endtask
  // Half-cycle pulses with a load sample; gaps let the estimate settle
  task automatic pulse(input logic [10:0] s, input int n);
    repeat (n) begin
      @(posedge i_clk);
      i_half_cycle  <= 1'b1;
      i_load_sample <= s;
      @(posedge i_clk);
      i_half_cycle <= 1'b0;
      repeat (3) @(posedge i_clk);
    end
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_reset();
    apb(1'b0, IDX_FINAL_LO, 8'h00, RST_BYTE, 1'b0);
    apb(1'b0, IDX_UPPER, 8'h00, RST_BYTE, 1'b0);
    apb(1'b0, IDX_LOWER, 8'h00, RST_BYTE, 1'b0);
    apb(1'b0, IDX_PGAIN, 8'h00, RST_BYTE, 1'b0);
    apb(1'b0, IDX_DGAIN, 8'h00, RST_BYTE, 1'b0);
    apb(1'b0, IDX_CTRL, 8'h00, {2'b00, RST_DELAY, RST_AVG}, 1'b0);
    apb(1'b0, IDX_OUT, 8'h00, RST_CEIL, 1'b0);
    $display("TB: reset test done");
  endtask
  task automatic t_regs();
    logic [7:0] ix[4];
    ix = '{IDX_FINAL_LO, IDX_UPPER, IDX_LOWER, IDX_PGAIN};
    foreach (ix[i]) begin
      apb(1'b1, ix[i], 8'ha5 + 8'(i), 8'h00, 1'b0);
      apb(1'b0, ix[i], 8'h00, 8'ha5 + 8'(i), 1'b0);
    end
    check({21'h0, o_final_learn_param}, 32'h0a5);
    apb(1'b1, IDX_DGAIN, 8'hff, 8'h00, 1'b0);
    apb(1'b0, IDX_DGAIN, 8'h00, 8'h0f, 1'b0);
    apb(1'b1, IDX_CTRL, 8'h3a, 8'h00, 1'b0);
    apb(1'b0, IDX_CTRL, 8'h00, 8'h3a, 1'b0);
    apb(1'b1, 8'h21, 8'h77, 8'h00, 1'b1);
    apb(1'b0, 8'h21, 8'h00, 8'h00, 1'b1);
    i_pstrb <= 4'h0;
    apb(1'b1, IDX_UPPER, 8'h11, 8'h00, 1'b0);
    i_pstrb <= 4'hf;
    apb(1'b0, IDX_UPPER, 8'h00, 8'ha6, 1'b0);
    $display("TB: register test done");
  endtask
  task automatic t_avg();
    int v[8];
    int e;
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, IDX_CTRL, {5'b00001, 3'(c)}, 8'h00, 1'b0);
      for (int k = 0; k < 8; k++) begin
        v[k] = k * 200 + c * 7;
        pulse(11'(v[k]), 1);
      end
      if (3'(c) == AVG_2) e = (v[7] + v[6]) >> 1;
      else if (3'(c) == AVG_4) e = (v[7] + v[6] + v[5] + v[4]) >> 2;
      else if (3'(c) == AVG_8) e = (v[0] + v[1] + v[2] + v[3] + v[4] + v[5] + v[6] + v[7]) >> 3;
      else e = v[7];
      check({21'h0, o_load_counter}, 32'(e));
    end
    apb(1'b0, IDX_LOAD_LO, 8'h00, 8'(e), 1'b0);
    apb(1'b0, IDX_LOAD_HI, 8'h00, {3'(e >> 8), 5'b00000}, 1'b0);
    $display("TB: averaging test done");
  endtask
  task automatic t_learn();
    pulse(11'h3c5, 1);
    apb(1'b1, IDX_CTRL, 8'h48, 8'h00, 1'b0);
    apb(1'b0, IDX_CTRL, 8'h00, 8'h48, 1'b0);
    check({31'h0, o_learning_active}, 32'h1);
    pulse(11'h3c5, 3);
    check({31'h0, o_learning_active}, 32'h0);
    apb(1'b0, IDX_CTRL, 8'h00, 8'h08, 1'b0);
    apb(1'b0, IDX_FINAL_LO, 8'h00, 8'hc5, 1'b0);
    apb(1'b0, IDX_LEARN_HI, 8'h00, 8'h23, 1'b0);
    check({21'h0, o_final_learn_param}, 32'h3c5);
    $display("TB: learning test done");
  endtask
  task automatic t_loop();
    apb(1'b1, IDX_UPPER, 8'h40, 8'h00, 1'b0);
    apb(1'b1, IDX_LOWER, 8'h20, 8'h00, 1'b0);
    apb(1'b1, IDX_PGAIN, 8'h10, 8'h00, 1'b0);
    apb(1'b1, IDX_DGAIN, 8'h00, 8'h00, 1'b0);
    pulse(11'h010, 1);
    apb(1'b1, IDX_CTRL, 8'h98, 8'h00, 1'b0);
    // The write lands on the edge the task returns at; look once it has settled
    @(negedge i_clk);
    check({31'h0, o_adaptive_enable}, 32'h1);
    pulse(11'h010, 6);
    check({24'h0, o_current_value}, 32'hdf);
    apb(1'b1, IDX_CTRL, 8'h88, 8'h00, 1'b0);
    pulse(11'h030, 3);
    check({24'h0, o_current_value}, 32'hcf);
    pulse(11'h050, 3);
    check({24'h0, o_current_value}, 32'hef);
    apb(1'b1, IDX_CEIL, 8'h80, 8'h00, 1'b0);
    apb(1'b0, IDX_OUT, 8'h00, 8'h80, 1'b0);
    apb(1'b1, IDX_CTRL, 8'h08, 8'h00, 1'b0);
    apb(1'b1, IDX_CEIL, 8'h90, 8'h00, 1'b0);
    apb(1'b0, IDX_OUT, 8'h00, 8'h90, 1'b0);
    $display("TB: current loop test done");
  endtask

  // ==========================================================================
  // Clock, sequence, watchdog and verdict
  // ==========================================================================
  task automatic summarize();
    $display("TB: %0d checks, %0d mismatches", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // Whole run is about six hundred cycles; the limit leaves a wide margin
  initial begin
    #200us;
    n_mismatch++;
    summarize();
  end
  initial begin
    {i_reset, i_psel, i_penable, i_pwrite, i_half_cycle} = 5'b10000;
    {i_paddr, i_pwdata, i_load_sample} = '0;
    i_pstrb = 4'hf;
    repeat (6) @(posedge i_clk);
    i_reset <= 1'b0;
    t_reset();
    t_regs();
    t_avg();
    t_learn();
    t_loop();
    summarize();
  end
endmodule
